// [rtl/mdpim_core.sv]
// Dual-port interface memory between host bus and signal processor
`timescale 1ns/1ps
`include "mdpim_map.svh"

module mdpim_core (
    input  wire logic                     core_clk_in,
    input  wire logic                     rst_in,
    // Host parallel bus pins, asynchronous to core_clk_in
    input  wire logic                     cs_n_in,
    input  wire logic [4:0]               register_select_lines_in,
    input  wire logic                     rd_n_in,
    input  wire logic                     wr_n_in,
    input  wire logic [7:0]               host_data_in,
    output logic      [7:0]               host_data_out,
    output logic                          host_data_oe_out,
    // Signal processor port, same clock
    input  wire logic [4:0]               dsp_addr_in,
    input  wire logic                     dsp_we_in,
    input  wire logic [7:0]               dsp_wmask_in,
    input  wire logic [7:0]               dsp_wdata_in,
    output logic      [7:0]               dsp_rdata_out,
    // Whole memory image and host access events for the modem logic
    output logic      [255:0]             regs_flat_out,
    output logic                          host_wr_pulse_out,
    output logic                          host_rd_pulse_out,
    output logic      [4:0]               host_acc_addr_out
);

    // Storage
    mdpim_pkg::mdpim_byte_t mem_q [`MDPIM_NUM_REGS];

    // Pin synchronisers: stage one feeds stage two only
    logic                    cs_n_s1_q;
    logic                    cs_n_s2_q;
    logic                    rd_n_s1_q;
    logic                    rd_n_s2_q;
    logic                    wr_n_s1_q;
    logic                    wr_n_s2_q;
    logic                    wr_n_s3_q;
    logic                    rd_act_s3_q;
    mdpim_pkg::mdpim_addr_t  addr_s1_q;
    mdpim_pkg::mdpim_addr_t  addr_s2_q;
    mdpim_pkg::mdpim_byte_t  data_s1_q;
    mdpim_pkg::mdpim_byte_t  data_s2_q;

    // Decoded host and processor events
    logic                    host_rd_act;
    logic                    host_wr_fire;
    logic                    dsp_wr_fire;
    logic                    wr_collide;
    mdpim_pkg::mdpim_byte_t  host_view;
    mdpim_pkg::mdpim_byte_t  dsp_view;

    // Fully spare registers hold nothing
    function automatic logic is_spare(input mdpim_pkg::mdpim_addr_t a);
        is_spare = (a == `MDPIM_OFS_SPARE_TWO) ||
                   (a == `MDPIM_OFS_SPARE_TWENTY) ||
                   (a == `MDPIM_OFS_SPARE_TWENTYONE);
    endfunction

    // Value seen by either reader
    function automatic mdpim_pkg::mdpim_byte_t read_view(input mdpim_pkg::mdpim_addr_t a,
                                                         input mdpim_pkg::mdpim_byte_t v);
        read_view = is_spare(a) ? `MDPIM_SPARE_READ : v;
    endfunction

    // Default contents after reset
    function automatic mdpim_pkg::mdpim_byte_t reset_value(input mdpim_pkg::mdpim_addr_t a);
        reset_value = (a == `MDPIM_OFS_TONE_VOICE) ? `MDPIM_RST_TONE_VOICE : `MDPIM_RST_DEFAULT;
    endfunction

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cs_n_s1_q <= 1'b1;
            cs_n_s2_q <= 1'b1;
            rd_n_s1_q <= 1'b1;
            rd_n_s2_q <= 1'b1;
            wr_n_s1_q <= 1'b1;
            wr_n_s2_q <= 1'b1;
            addr_s1_q <= 5'h00;
            addr_s2_q <= 5'h00;
            data_s1_q <= 8'h00;
            data_s2_q <= 8'h00;
        end else begin
            cs_n_s1_q <= cs_n_in;
            cs_n_s2_q <= cs_n_s1_q;
            rd_n_s1_q <= rd_n_in;
            rd_n_s2_q <= rd_n_s1_q;
            wr_n_s1_q <= wr_n_in;
            wr_n_s2_q <= wr_n_s1_q;
            addr_s1_q <= register_select_lines_in;
            addr_s2_q <= addr_s1_q;
            data_s1_q <= host_data_in;
            data_s2_q <= data_s1_q;
        end
    end

    // Strobe history for edge detection
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wr_n_s3_q   <= 1'b1;
            rd_act_s3_q <= 1'b0;
        end else begin
            wr_n_s3_q   <= wr_n_s2_q;
            rd_act_s3_q <= host_rd_act;
        end
    end

    // Write is taken at the trailing edge of the strobe, when the bus data has settled
    always_comb begin
        host_rd_act  = !cs_n_s2_q && !rd_n_s2_q;
        host_wr_fire = !cs_n_s2_q && wr_n_s2_q && !wr_n_s3_q;
        dsp_wr_fire  = dsp_we_in && !is_spare(dsp_addr_in);
        wr_collide   = host_wr_fire && dsp_wr_fire && (dsp_addr_in == addr_s2_q);
        host_view    = read_view(addr_s2_q, mem_q[addr_s2_q]);
        dsp_view     = read_view(dsp_addr_in, mem_q[dsp_addr_in]);
    end

    // Storage update: reset defaults, host byte write, masked processor write
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < `MDPIM_NUM_REGS; i++) begin
                mem_q[i] <= reset_value(mdpim_pkg::mdpim_addr_t'(i));
            end
        end else begin
            // Processor write is dropped when a host write to the same cell fires in the same cycle, so the host wins
            if (dsp_wr_fire && !wr_collide) begin
                mem_q[dsp_addr_in] <= (mem_q[dsp_addr_in] & ~dsp_wmask_in) |
                                      (dsp_wdata_in & dsp_wmask_in);
            end
            if (host_wr_fire && !is_spare(addr_s2_q)) begin
                mem_q[addr_s2_q] <= data_s2_q;
            end
        end
    end

    // Host read path: data driven only while chip select and read strobe are low
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            host_data_out    <= 8'h00;
            host_data_oe_out <= 1'b0;
        end else begin
            host_data_oe_out <= host_rd_act;
            if (host_rd_act) begin
                host_data_out <= host_view;
            end else begin
                host_data_out <= 8'h00;
            end
        end
    end

    // Processor read path, one cycle latency
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            dsp_rdata_out <= 8'h00;
        end else begin
            dsp_rdata_out <= dsp_view;
        end
    end

    // Host access events let the modem logic act on commands and consumed buffers
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            host_wr_pulse_out <= 1'b0;
            host_rd_pulse_out <= 1'b0;
            host_acc_addr_out <= 5'h00;
        end else begin
            host_wr_pulse_out <= host_wr_fire && !is_spare(addr_s2_q);
            host_rd_pulse_out <= !host_rd_act && rd_act_s3_q;
            if (host_wr_fire || host_rd_act) begin
                host_acc_addr_out <= addr_s2_q;
            end
        end
    end

    // Image of all registers, bit k of register z at index 8*z+k
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            regs_flat_out <= '0;
        end else begin
            for (int z = 0; z < `MDPIM_NUM_REGS; z++) begin
                regs_flat_out[8*z +: 8] <= mem_q[z];
            end
        end
    end

    // Checks
    property p_host_write;
        @(posedge core_clk_in) disable iff (rst_in)
        host_wr_fire && !is_spare(addr_s2_q) |=> mem_q[$past(addr_s2_q)] == $past(data_s2_q);
    endproperty
    a_host_write: assert property (p_host_write) else $error("host write not stored");

    property p_spare_zero;
        @(posedge core_clk_in) disable iff (rst_in)
        host_rd_act && is_spare(addr_s2_q) |=> host_data_out == 8'h00;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare register read not zero");

    property p_spare_hold;
        @(posedge core_clk_in) disable iff (rst_in)
        mem_q[2] == 8'h00 && mem_q[20] == 8'h00 && mem_q[21] == 8'h00;
    endproperty
    a_spare_hold: assert property (p_spare_hold) else $error("spare register changed");

    property p_collide;
        @(posedge core_clk_in) disable iff (rst_in)
        wr_collide && !is_spare(addr_s2_q) |=> mem_q[$past(addr_s2_q)] == $past(data_s2_q);
    endproperty
    a_collide: assert property (p_collide) else $error("host did not win collision");

    property p_reset_default;
        @(posedge core_clk_in)
        rst_in |=> mem_q[5] == 8'h08 && mem_q[0] == 8'h00 && mem_q[18] == 8'h00;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("reset default wrong");

    property p_read_data;
        @(posedge core_clk_in) disable iff (rst_in)
        host_rd_act |=> host_data_oe_out && host_data_out == $past(host_view);
    endproperty
    a_read_data: assert property (p_read_data) else $error("host read data wrong");

    property p_read_latency;
        @(posedge core_clk_in) disable iff (rst_in)
        (!cs_n_in && !rd_n_in)[*3] |=> host_data_oe_out;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read not answered in time");

    property p_oe_needs_cs;
        @(posedge core_clk_in) disable iff (rst_in)
        host_data_oe_out |-> $past(!cs_n_s2_q);
    endproperty
    a_oe_needs_cs: assert property (p_oe_needs_cs) else $error("bus driven without chip select");

    property p_wr_event;
        @(posedge core_clk_in) disable iff (rst_in)
        host_wr_fire && !is_spare(addr_s2_q) |=> host_wr_pulse_out ##1 !host_wr_pulse_out;
    endproperty
    a_wr_event: assert property (p_wr_event) else $error("write event pulse wrong");

    property p_dsp_write;
        @(posedge core_clk_in) disable iff (rst_in)
        dsp_wr_fire && !wr_collide && dsp_wmask_in == 8'hff && !(host_wr_fire && !is_spare(addr_s2_q))
        |=> mem_q[$past(dsp_addr_in)] == $past(dsp_wdata_in);
    endproperty
    a_dsp_write: assert property (p_dsp_write) else $error("processor write not stored");

    // Image lags storage by one cycle, so a quiet cycle shows up two edges later
    property p_image_hold;
        @(posedge core_clk_in) disable iff (rst_in)
        !host_wr_fire && !dsp_wr_fire |=> ##1 $stable(regs_flat_out);
    endproperty
    a_image_hold: assert property (p_image_hold) else $error("register image changed without a write");

    property p_image_map;
        @(posedge core_clk_in) disable iff (rst_in)
        1'b1 |=> regs_flat_out[8*9+2] == $past(mem_q[9][2]);
    endproperty
    a_image_map: assert property (p_image_map) else $error("image bit position wrong");

    property p_dsp_spare;
        @(posedge core_clk_in) disable iff (rst_in)
        is_spare(dsp_addr_in) |=> dsp_rdata_out == 8'h00;
    endproperty
    a_dsp_spare: assert property (p_dsp_spare) else $error("processor spare read not zero");

    property p_dsp_read;
        @(posedge core_clk_in) disable iff (rst_in)
        !is_spare(dsp_addr_in) |=> dsp_rdata_out == $past(mem_q[dsp_addr_in]);
    endproperty
    a_dsp_read: assert property (p_dsp_read) else $error("processor read data wrong");

    property p_oe_drop;
        @(posedge core_clk_in) disable iff (rst_in)
        !host_rd_act |=> !host_data_oe_out && host_data_out == 8'h00;
    endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("bus driven outside a read");

    property p_acc_addr;
        @(posedge core_clk_in) disable iff (rst_in)
        host_wr_fire |=> host_acc_addr_out == $past(addr_s2_q);
    endproperty
    a_acc_addr: assert property (p_acc_addr) else $error("access address wrong");

    property p_spare_no_pulse;
        @(posedge core_clk_in) disable iff (rst_in)
        host_wr_fire && is_spare(addr_s2_q) |=> !host_wr_pulse_out;
    endproperty
    a_spare_no_pulse: assert property (p_spare_no_pulse) else $error("spare write raised event");

    property p_reset_outputs;
        @(posedge core_clk_in)
        rst_in |=> !host_data_oe_out && !host_wr_pulse_out && !host_rd_pulse_out && dsp_rdata_out == 8'h00;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared by reset");

    property p_rd_event;
        @(posedge core_clk_in) disable iff (rst_in)
        host_rd_act ##1 !host_rd_act |=> host_rd_pulse_out;
    endproperty
    a_rd_event: assert property (p_rd_event) else $error("read end event missing");

    property p_wr_pulse_src;
        @(posedge core_clk_in) disable iff (rst_in)
        host_wr_pulse_out |-> $past(host_wr_fire);
    endproperty
    a_wr_pulse_src: assert property (p_wr_pulse_src) else $error("write event without strobe");

    property p_oe_needs_rd;
        @(posedge core_clk_in) disable iff (rst_in)
        host_data_oe_out |-> $past(!rd_n_s2_q);
    endproperty
    a_oe_needs_rd: assert property (p_oe_needs_rd) else $error("bus driven without read strobe");

    c_host_write: cover property (@(posedge core_clk_in) disable iff (rst_in) host_wr_fire);
    c_collide:    cover property (@(posedge core_clk_in) disable iff (rst_in) wr_collide);
    c_read_back:  cover property (@(posedge core_clk_in) disable iff (rst_in)
                                  host_wr_fire ##[1:20] host_rd_act);
    c_dsp_write:  cover property (@(posedge core_clk_in) disable iff (rst_in) dsp_wr_fire && !wr_collide);
    c_spare_read: cover property (@(posedge core_clk_in) disable iff (rst_in) host_rd_act && is_spare(addr_s2_q));

endmodule

// [shared/mdpim_map.svh]
// Register offsets, reset values and field constants of the modem interface memory
// Behaviour
// - Thirty-two eight-bit registers, numbered 00 through 1F.
// - Host and signal processor can both read every register and write all but spares 02, 14 and 15.
// - Host reaches the registers only through the parallel bus port.
// - Any register accepts a host read in every bus cycle; only non-spare registers (all but 02, 14 and 15) accept a host write.
// - Bits named as register number plus index 0..7, zero being LSB.
// - Host writes steer modem logic and reach processor RAM parameters.
// - Host reads show status bits and processor RAM read-back values.
// - With chip select low, five select lines choose one of 32 registers.
// - Low read or write strobe pulse performs the host access.
// - Host write copies the bus byte, high as one, low as zero.
// - Reset loads every register bit with its default value.
`ifndef MDPIM_MAP_SVH
`define MDPIM_MAP_SVH

`define MDPIM_NUM_REGS            32
`define MDPIM_ADDR_W              5
`define MDPIM_DATA_W              8

`define MDPIM_OFS_RX_BYTE_BUF     5'h00
`define MDPIM_OFS_RX_PARITY       5'h01
`define MDPIM_OFS_SPARE_TWO       5'h02
`define MDPIM_OFS_SYNC_CODING     5'h03
`define MDPIM_OFS_EQ_FREEZE       5'h04
`define MDPIM_OFS_TONE_VOICE      5'h05
`define MDPIM_OFS_ASYNC_FORMAT    5'h06
`define MDPIM_OFS_LOOPBACK_RELAY  5'h07
`define MDPIM_OFS_DATA_PATH       5'h08
`define MDPIM_OFS_CALL_MODE       5'h09
`define MDPIM_OFS_CHECK_SEND      5'h0a
`define MDPIM_OFS_TONE_DETECT     5'h0b
`define MDPIM_OFS_KEYPAD_DIGIT    5'h0c
`define MDPIM_OFS_SEQ_DETECT      5'h0d
`define MDPIM_OFS_ASYNC_ERR       5'h0e
`define MDPIM_OFS_LINE_STATUS     5'h0f
`define MDPIM_OFS_TX_BYTE_BUF     5'h10
`define MDPIM_OFS_TX_PARITY       5'h11
`define MDPIM_OFS_OP_MODE         5'h12
`define MDPIM_OFS_TX_LEVEL        5'h13
`define MDPIM_OFS_SPARE_TWENTY    5'h14
`define MDPIM_OFS_SPARE_TWENTYONE 5'h15
`define MDPIM_OFS_Y_WORD_LOW      5'h16
`define MDPIM_OFS_Y_WORD_HIGH     5'h17
`define MDPIM_OFS_X_WORD_LOW      5'h18
`define MDPIM_OFS_X_WORD_HIGH     5'h19
`define MDPIM_OFS_Y_POINTER       5'h1a
`define MDPIM_OFS_Y_ACCESS        5'h1b
`define MDPIM_OFS_X_POINTER       5'h1c
`define MDPIM_OFS_X_ACCESS        5'h1d
`define MDPIM_OFS_BUF_IRQ         5'h1e
`define MDPIM_OFS_UPD_IRQ         5'h1f

`define MDPIM_RST_TONE_VOICE      8'h08
`define MDPIM_RST_DEFAULT         8'h00
`define MDPIM_SPARE_READ          8'h00

`endif

// [shared/mdpim_pkg.sv]
// Types shared by the modem interface memory
package mdpim_pkg;
    typedef logic [4:0] mdpim_addr_t;
    typedef logic [7:0] mdpim_byte_t;
endpackage

// [verif/mdpim_host_model.sv]
// Host microprocessor model driving the modem interface memory bus pins
`timescale 1ns/1ps

module mdpim_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] dev_data_in,
    input  wire logic       dev_oe_in,
    output logic            cs_n_out,
    output logic [4:0]      sel_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic [7:0]      bus_out
);
    logic       drive_q;
    logic [7:0] wdata_q;
    logic [7:0] last_q;

    // A released bus flips every cycle so stale data cannot pass for a read
    assign bus_out = dev_oe_in ? dev_data_in : (drive_q ? wdata_q : ~last_q);

    always @(posedge clk_in) last_q <= bus_out;

    initial begin
        cs_n_out = 1'b1;
        sel_out  = 5'h00;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        drive_q  = 1'b0;
        wdata_q  = 8'h00;
        last_q   = 8'h00;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Whole byte per write, so bit changes need a read first
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic sel_n);
        cs_n_out = sel_n;
        sel_out  = a;
        wdata_q  = d;
        drive_q  = 1'b1;
        wr_n_out = 1'b0;
        cyc(4);
        wr_n_out = 1'b1;
        cyc(4);
        cs_n_out = 1'b1;
        drive_q  = 1'b0;
        cyc(4);
    endtask

    task automatic rd(input logic [4:0] a, input logic sel_n, output logic [7:0] d);
        int n;
        cs_n_out = sel_n;
        sel_out  = a;
        rd_n_out = 1'b0;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (dev_oe_in !== 1'b1 && n < 8);
        // Data is taken while it stands, not in the time step of the edge that updates it
        d = dev_data_in;
        @(posedge clk_in);
        #1;
        rd_n_out = 1'b1;
        cs_n_out = 1'b1;
        cyc(5);
    endtask
endmodule

// [verif/testbench.sv]
// Self-checking testbench of the modem interface memory
`timescale 1ns/1ps
`include "mdpim_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %0t value %h expected %h", $time, g, e); end end

module testbench;
    logic         core_clk_in, rst_in, cs_n, rd_n, wr_n, oe, wpulse, rpulse, dsp_we;
    logic [4:0]   sel, dsp_addr, acc_addr;
    logic [7:0]   hdi, hdo, dsp_wmask, dsp_wdata, dsp_rdata, rb;
    logic [255:0] image;
    int           err_count = 0, compares = 0, wr_pulses = 0, rd_pulses = 0, w0;

    mdpim_host_model u_host (.clk_in(core_clk_in), .dev_data_in(hdo), .dev_oe_in(oe), .cs_n_out(cs_n),
        .sel_out(sel), .rd_n_out(rd_n), .wr_n_out(wr_n), .bus_out(hdi));
    mdpim_core u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
        .register_select_lines_in(sel), .rd_n_in(rd_n), .wr_n_in(wr_n), .host_data_in(hdi),
        .host_data_out(hdo), .host_data_oe_out(oe), .dsp_addr_in(dsp_addr), .dsp_we_in(dsp_we),
        .dsp_wmask_in(dsp_wmask), .dsp_wdata_in(dsp_wdata), .dsp_rdata_out(dsp_rdata),
        .regs_flat_out(image), .host_wr_pulse_out(wpulse), .host_rd_pulse_out(rpulse),
        .host_acc_addr_out(acc_addr));

    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in) begin
        wr_pulses <= wr_pulses + int'(wpulse === 1'b1);
        rd_pulses <= rd_pulses + int'(rpulse === 1'b1);
    end

    function automatic logic [7:0] pat(input int i);
        return {i[2:0], i[4:0]};
    endfunction

    function automatic logic spare(input int i);
        return i == 2 || i == 20 || i == 21;
    endfunction

    task automatic dsp_wr(input logic [4:0] a, input logic [7:0] m, input logic [7:0] d);
        dsp_addr  = a;
        dsp_wmask = m;
        dsp_wdata = d;
        dsp_we    = 1'b1;
        @(posedge core_clk_in);
        #1 dsp_we = 1'b0;
        // One idle edge so a following call never lowers and raises the strobe at once
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #60000;
        err_count++;
        print_verdict();
    end

    initial begin
        dsp_we = 1'b0;
        dsp_addr = 5'h00;
        dsp_wmask = 8'h00;
        dsp_wdata = 8'h00;
        rst_in = 1'b1;
        repeat (6) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        for (int i = 0; i < 32; i++) begin
            u_host.rd(5'(i), 1'b0, rb);
            `CHK(rb, (i == 5) ? 8'h08 : 8'h00)
        end
        `CHK(rd_pulses, 32)
        `CHK(image, 256'h0800_0000_0000)
        $display("test reset values done");
        w0 = wr_pulses;
        for (int i = 0; i < 32; i++) u_host.wr(5'(i), pat(i), 1'b0);
        `CHK(acc_addr, 5'h1f)
        `CHK(wr_pulses - w0, 29)
        for (int i = 0; i < 32; i++) begin
            u_host.rd(5'(i), 1'b0, rb);
            `CHK(rb, spare(i) ? 8'h00 : pat(i))
            `CHK(image[8*i+:8], spare(i) ? 8'h00 : pat(i))
        end
        $display("test write all done");
        u_host.rd(`MDPIM_OFS_CALL_MODE, 1'b0, rb);
        u_host.wr(`MDPIM_OFS_CALL_MODE, rb | 8'h04, 1'b0);
        `CHK(image[8*9+2], 1'b1)
        u_host.rd(`MDPIM_OFS_CALL_MODE, 1'b0, rb);
        `CHK(rb, 8'h2d)
        $display("test read modify write done");
        dsp_addr = `MDPIM_OFS_Y_WORD_LOW;
        @(posedge core_clk_in);
        #1;
        `CHK(dsp_rdata, 8'hd6)
        dsp_wr(`MDPIM_OFS_Y_WORD_LOW, 8'h0f, 8'ha5);
        dsp_wr(`MDPIM_OFS_SPARE_TWENTY, 8'hff, 8'hff);
        dsp_wr(`MDPIM_OFS_X_WORD_HIGH, 8'hff, 8'h5a);
        u_host.rd(`MDPIM_OFS_Y_WORD_LOW, 1'b0, rb);
        `CHK(rb, 8'hd5)
        u_host.rd(`MDPIM_OFS_SPARE_TWENTY, 1'b0, rb);
        `CHK(rb, 8'h00)
        u_host.rd(`MDPIM_OFS_X_WORD_HIGH, 1'b0, rb);
        `CHK(rb, 8'h5a)
        $display("test processor port done");
        fork
            u_host.wr(`MDPIM_OFS_RX_BYTE_BUF, 8'h3c, 1'b0);
            begin
                @(posedge wr_n);
                repeat (2) @(posedge core_clk_in);
                #1;
                dsp_wr(`MDPIM_OFS_RX_BYTE_BUF, 8'hff, 8'hc3);
            end
        join
        u_host.rd(`MDPIM_OFS_RX_BYTE_BUF, 1'b0, rb);
        `CHK(rb, 8'h3c)
        $display("test collision done");
        w0 = wr_pulses;
        u_host.wr(`MDPIM_OFS_RX_BYTE_BUF, 8'h99, 1'b1);
        u_host.rd(`MDPIM_OFS_RX_BYTE_BUF, 1'b1, rb);
        `CHK(rb, 8'h00)
        `CHK(wr_pulses - w0, 0)
        u_host.rd(`MDPIM_OFS_RX_BYTE_BUF, 1'b0, rb);
        `CHK(rb, 8'h3c)
        $display("test deselected bus done");
        rst_in = 1'b1;
        repeat (3) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        u_host.rd(`MDPIM_OFS_TONE_VOICE, 1'b0, rb);
        `CHK(rb, `MDPIM_RST_TONE_VOICE)
        u_host.rd(`MDPIM_OFS_Y_WORD_LOW, 1'b0, rb);
        `CHK(rb, `MDPIM_RST_DEFAULT)
        $display("test second reset done");
        print_verdict();
    end
endmodule
